// *** common/i2c_host_pkg.sv ***
package i2c_host_pkg;

  // ==========================================================
  // device register indices on the register port
  localparam logic [1:0] DEV_CTRL = 2'h0;
  localparam logic [1:0] DEV_DATA = 2'h1;
  localparam logic [1:0] DEV_STAT = 2'h2;

  // ==========================================================
  // bus_control_reg field positions
  localparam int IRQ_ALLOW_POS = 7;
  localparam int BUS_ON_POS = 6;
  localparam int BEGIN_POS = 5;
  localparam int HALT_POS = 4;
  localparam int FLAG_POS = 3;
  localparam int ACK_ASSERT_POS = 2;

  // ==========================================================
  // condition codes
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RESTART = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK = 8'h18;
  localparam logic [7:0] ST_ADDR_NACK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK = 8'h28;
  localparam logic [7:0] ST_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_ARB_SLV_WR = 8'h68;
  localparam logic [7:0] ST_ARB_GCALL = 8'h78;
  localparam logic [7:0] ST_ARB_SLV_RD = 8'hB0;

  // ==========================================================
  // own wishbone registers, byte addresses
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_SLA = 8'h04;
  localparam logic [7:0] WB_LEN = 8'h08;
  localparam logic [7:0] WB_STAT = 8'h0C;
  localparam logic [2:0] WB_TXBUF_PAGE = 3'h1;
  localparam int CMD_GO_POS = 0;
  localparam int CMD_IEN_POS = 1;
  localparam int CMD_AAK_POS = 2;
  localparam int CMD_RETRY_POS = 3;
  localparam logic [6:0] SLA_RESET = 7'h00;
  localparam logic [3:0] LEN_RESET = 4'h0;
  localparam int TX_DEPTH = 8;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // ==========================================================
  // register port timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACC_HOLD_NS = 80;
  localparam int ACC_HOLD_CYCLES =
    (ACC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** src/dev_port_access.sv ***
module dev_port_access
  import i2c_host_pkg::*;
#(
  parameter int HOLD = ACC_HOLD_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] data_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic [1:0] dev_addr_o,
  output logic [7:0] dev_wdata_o,
  output logic dev_wr_o,
  output logic dev_rd_o,
  input wire logic [7:0] dev_rdata_i
);

  typedef enum logic [1:0] {A_IDLE, A_HOLD, A_FIN} acc_state_t;

  localparam logic [7:0] HOLD_LAST = 8'(HOLD - 1);

  acc_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [7:0] next_rdata;
  logic [1:0] next_addr;
  logic [7:0] next_wdata;
  logic next_wr, next_rd;
  logic [7:0] s1, s2, s3, stable, next_stable;

  // ==========================================================
  // read data sync: stage one feeds only stage two
  always_comb begin
    next_stable = (s2 == s3) ? s3 : stable;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3 <= 8'h00;
      stable <= 8'h00;
    end else begin
      s1 <= dev_rdata_i;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable;
    end
  end

  // ==========================================================
  // one strobed access, held long enough to outlast the sync
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rdata = rdata_o;
    next_addr = dev_addr_o;
    next_wdata = dev_wdata_o;
    next_wr = dev_wr_o;
    next_rd = dev_rd_o;
    unique case (state)
      A_IDLE: begin
        if (req_i) begin
          next_addr = addr_i;
          next_wdata = data_i;
          next_wr = wr_i;
          next_rd = !wr_i;
          next_cnt = 8'h00;
          next_state = A_HOLD;
        end
      end
      A_HOLD: begin
        next_cnt = cnt + 8'h01;
        if (cnt == HOLD_LAST) begin
          next_wr = 1'b0;
          next_rd = 1'b0;
          next_rdata = stable;
          next_state = A_FIN;
        end
      end
      A_FIN: next_state = A_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= A_IDLE;
      cnt <= 8'h00;
      rdata_o <= 8'h00;
      dev_addr_o <= 2'h0;
      dev_wdata_o <= 8'h00;
      dev_wr_o <= 1'b0;
      dev_rd_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rdata_o <= next_rdata;
      dev_addr_o <= next_addr;
      dev_wdata_o <= next_wdata;
      dev_wr_o <= next_wr;
      dev_rd_o <= next_rd;
    end
  end

  assign done_o = (state == A_FIN);

endmodule

// *** src/i2c_tx_host.sv ***
// How it works
// - program control with bus on, begin, halt, flag and low bits clear
// - setting begin starts a transfer; device sends START once bus free
// - address byte carries slave address in 7:1 and write zero in 0
// - device waits for flag clear, then raises it with a new code
// - on 18 send data, begin, halt, or both by the flag clear (here: first data byte, or halt when len is zero)
// - on B0 load a byte and clear; ack-assert zero marks it last
// - after 18 or 20 load first data byte before clearing flag (here: on 20 nack is set and halt is sent instead)
// - on 28 send data, begin, halt, or both by the flag clear (here: next data byte, or halt once len bytes are sent)
// - halt request sends STOP, device clears halt itself, goes idle
// - a full slave receiver leaves acknowledge undriven, giving NACK
module i2c_tx_host
  import i2c_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic [1:0] dev_addr_o,
  output logic [7:0] dev_wdata_o,
  output logic dev_wr_o,
  output logic dev_rd_o,
  input wire logic [7:0] dev_rdata_i,
  input wire logic dev_irq_i
);

  typedef enum logic [3:0] {
    M_IDLE, M_INIT, M_BEGIN, M_POLL, M_IRQ, M_STAT, M_EVAL, M_WADDR,
    M_WDATA, M_ARBDATA, M_CLEAR, M_HALT, M_HALTPOLL
  } host_state_t;

  function automatic logic [7:0] ctrl_byte(input logic irq_allow_bit,
      input logic beg, input logic halt, input logic ack_assert_bit);
    logic [7:0] b;
    b = 8'h00;
    b[IRQ_ALLOW_POS] = irq_allow_bit;
    b[BUS_ON_POS] = 1'b1;
    b[BEGIN_POS] = beg;
    b[HALT_POS] = halt;
    b[ACK_ASSERT_POS] = ack_assert_bit;
    return b;
  endfunction

  // ==========================================================
  // wishbone slave and own registers
  logic irq_allow_bit, ack_assert_bit, retry, next_ien, next_aak, next_retry;
  logic [6:0] sla, next_sla;
  logic [3:0] len, next_len;
  logic [7:0] txbuf [TX_DEPTH];
  logic [7:0] next_txbuf [TX_DEPTH];
  logic next_ack;
  logic [31:0] next_dat;
  logic wb_hit, wb_wr, go_req;
  host_state_t state, next_state, wait_state;
  logic [7:0] code, next_code, out_byte, next_out, bus_byte, next_bus;
  logic [3:0] idx, next_idx;
  logic clr_begin, clr_aak, after_clear;
  logic next_clr_begin, next_clr_aak, next_after;
  logic done_f, nack, arb, err;
  logic next_done, next_nack, next_arb, next_err;

  assign wb_hit = cyc_i && stb_i && !ack_o;
  assign wb_wr = wb_hit && we_i && sel_i[0];
  assign go_req = wb_wr && adr_i == WB_CMD && dat_i[CMD_GO_POS];

  always_comb begin
    next_ack = wb_hit;
    next_dat = dat_o;
    next_ien = irq_allow_bit;
    next_aak = ack_assert_bit;
    next_retry = retry;
    next_sla = sla;
    next_len = len;
    next_txbuf = txbuf;
    if (wb_wr) begin
      if (adr_i == WB_CMD) begin
        next_ien = dat_i[CMD_IEN_POS];
        next_aak = dat_i[CMD_AAK_POS];
        next_retry = dat_i[CMD_RETRY_POS];
      end
      if (adr_i == WB_SLA) next_sla = dat_i[6:0];
      if (adr_i == WB_LEN) next_len = dat_i[3:0];
      if (adr_i[7:5] == WB_TXBUF_PAGE) next_txbuf[adr_i[4:2]] = dat_i[7:0];
    end
    if (wb_hit && !we_i) begin
      next_dat = 32'h0000_0000;
      if (adr_i == WB_CMD)
        next_dat = {28'h000_0000, retry, ack_assert_bit, irq_allow_bit, 1'b0};
      if (adr_i == WB_SLA) next_dat = {25'h000_0000, sla};
      if (adr_i == WB_LEN) next_dat = {28'h000_0000, len};
      if (adr_i == WB_STAT)
        next_dat = {8'h00, bus_byte, code, 3'h0, err, arb, nack, done_f,
                    state != M_IDLE};
      if (adr_i[7:5] == WB_TXBUF_PAGE)
        next_dat = {24'h00_0000, txbuf[adr_i[4:2]]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq_allow_bit <= 1'b0;
      ack_assert_bit <= 1'b0;
      retry <= 1'b0;
      sla <= SLA_RESET;
      len <= LEN_RESET;
      for (int i = 0; i < TX_DEPTH; i++) txbuf[i] <= 8'h00;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
      irq_allow_bit <= next_ien;
      ack_assert_bit <= next_aak;
      retry <= next_retry;
      sla <= next_sla;
      len <= next_len;
      txbuf <= next_txbuf;
    end
  end

  // ==========================================================
  // device interrupt sync, change taken once stages 2 and 3 agree
  logic i1, i2, i3, irq_s, next_irq_s;

  always_comb begin
    next_irq_s = (i2 == i3) ? i3 : irq_s;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      i1 <= 1'b0;
      i2 <= 1'b0;
      i3 <= 1'b0;
      irq_s <= 1'b0;
    end else begin
      i1 <= dev_irq_i;
      i2 <= i1;
      i3 <= i2;
      irq_s <= next_irq_s;
    end
  end

  // ==========================================================
  // device register port accesses per state
  logic acc_req, acc_wr, acc_done;
  logic [1:0] acc_addr;
  logic [7:0] acc_data, acc_rdata;

  always_comb begin
    acc_req = 1'b1;
    acc_wr = 1'b1;
    acc_addr = DEV_CTRL;
    acc_data = 8'h00;
    unique case (state)
      M_INIT: acc_data = ctrl_byte(irq_allow_bit, 1'b0, 1'b0, ack_assert_bit);
      M_BEGIN: acc_data = ctrl_byte(irq_allow_bit, 1'b1, 1'b0, ack_assert_bit);
      M_POLL, M_HALTPOLL: acc_wr = 1'b0;
      M_STAT: begin
        acc_wr = 1'b0;
        acc_addr = DEV_STAT;
      end
      M_WADDR: begin
        acc_addr = DEV_DATA;
        acc_data = {sla, 1'b0};
      end
      M_WDATA: begin
        acc_addr = DEV_DATA;
        acc_data = out_byte;
      end
      M_ARBDATA: begin
        acc_wr = 1'b0;
        acc_addr = DEV_DATA;
      end
      // flag bit stays zero, so this write releases the device
      M_CLEAR: acc_data = ctrl_byte(irq_allow_bit, clr_begin, 1'b0, clr_aak);
      M_HALT: acc_data = ctrl_byte(irq_allow_bit, 1'b0, 1'b1, ack_assert_bit);
      M_IDLE, M_IRQ, M_EVAL: acc_req = 1'b0;
    endcase
  end

  dev_port_access #(.HOLD(ACC_HOLD_CYCLES)) u_acc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(acc_req),
    .wr_i(acc_wr),
    .addr_i(acc_addr),
    .data_i(acc_data),
    .done_o(acc_done),
    .rdata_o(acc_rdata),
    .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o),
    .dev_wr_o(dev_wr_o),
    .dev_rd_o(dev_rd_o),
    .dev_rdata_i(dev_rdata_i)
  );

  // ==========================================================
  // transfer sequencer
  always_comb begin
    wait_state = irq_allow_bit ? M_IRQ : M_POLL;
    next_state = state;
    next_code = code;
    next_idx = idx;
    next_out = out_byte;
    next_bus = bus_byte;
    next_clr_begin = clr_begin;
    next_clr_aak = clr_aak;
    next_after = after_clear;
    next_done = done_f;
    next_nack = nack;
    next_arb = arb;
    next_err = err;
    unique case (state)
      M_IDLE: begin
        if (go_req) begin
          next_state = M_INIT;
          next_idx = 4'h0;
          next_done = 1'b0;
          next_nack = 1'b0;
          next_arb = 1'b0;
          next_err = 1'b0;
        end
      end
      M_INIT: if (acc_done) next_state = M_BEGIN;
      M_BEGIN: if (acc_done) next_state = wait_state;
      // bus clock is held low by the device meanwhile
      M_POLL: if (acc_done && acc_rdata[FLAG_POS]) next_state = M_STAT;
      M_IRQ: if (irq_s) next_state = M_STAT;
      M_STAT: begin
        if (acc_done) begin
          next_code = acc_rdata;
          next_state = M_EVAL;
        end
      end
      M_EVAL: begin
        next_clr_begin = 1'b0;
        next_clr_aak = ack_assert_bit;
        next_after = 1'b1;
        case (code)
          ST_START, ST_RESTART: next_state = M_WADDR;
          ST_ADDR_ACK, ST_DATA_ACK: begin
            if (idx < len) begin
              next_out = txbuf[idx[2:0]];
              next_idx = idx + 4'h1;
              next_state = M_WDATA;
            end else begin
              next_state = M_HALT;
            end
          end
          // receiver refused: stop rather than push on
          ST_ADDR_NACK, ST_DATA_NACK: begin
            next_nack = 1'b1;
            next_state = M_HALT;
          end
          ST_ARB_LOST: begin
            next_arb = 1'b1;
            next_clr_begin = retry;
            next_after = retry;
            next_idx = 4'h0;
            next_state = M_ARBDATA;
          end
          ST_ARB_SLV_WR, ST_ARB_GCALL: begin
            next_arb = 1'b1;
            next_after = 1'b0;
            next_state = M_CLEAR;
          end
          ST_ARB_SLV_RD: begin
            next_arb = 1'b1;
            next_out = FILL_BYTE;
            next_clr_aak = 1'b0;
            next_after = 1'b0;
            next_state = M_WDATA;
          end
          default: begin
            next_err = 1'b1;
            next_state = M_HALT;
          end
        endcase
      end
      M_WADDR, M_WDATA: if (acc_done) next_state = M_CLEAR;
      M_ARBDATA: begin
        if (acc_done) begin
          next_bus = acc_rdata; // byte that won the bus
          next_state = M_CLEAR;
        end
      end
      M_CLEAR: begin
        if (acc_done) begin
          next_state = after_clear ? wait_state : M_IDLE;
          next_done = !after_clear;
        end
      end
      M_HALT: if (acc_done) next_state = M_HALTPOLL;
      M_HALTPOLL: begin
        if (acc_done && !acc_rdata[HALT_POS]) begin
          next_state = M_IDLE;
          next_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= M_IDLE;
      code <= 8'h00;
      idx <= 4'h0;
      out_byte <= 8'h00;
      bus_byte <= 8'h00;
      clr_begin <= 1'b0;
      clr_aak <= 1'b0;
      after_clear <= 1'b0;
      done_f <= 1'b0;
      nack <= 1'b0;
      arb <= 1'b0;
      err <= 1'b0;
    end else begin
      state <= next_state;
      code <= next_code;
      idx <= next_idx;
      out_byte <= next_out;
      bus_byte <= next_bus;
      clr_begin <= next_clr_begin;
      clr_aak <= next_clr_aak;
      after_clear <= next_after;
      done_f <= next_done;
      nack <= next_nack;
      arb <= next_arb;
      err <= next_err;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_init_ctrl_value: assert property (state == M_INIT |->
    acc_wr && acc_addr == DEV_CTRL && acc_data[BUS_ON_POS] &&
    acc_data[5:3] == 3'h0 && acc_data[1:0] == 2'h0)
    else $error("init control value wrong");
  a_begin_after_init: assert property (
    state == M_INIT && acc_done |=> state == M_BEGIN &&
    acc_data[BEGIN_POS] && !acc_data[HALT_POS])
    else $error("begin not written after init");
  a_start_to_addr: assert property (
    state == M_EVAL && code == ST_START |=> state == M_WADDR)
    else $error("start code did not lead to address");
  a_restart_to_addr: assert property (
    state == M_EVAL && code == ST_RESTART |=> state == M_WADDR)
    else $error("restart code did not lead to address");
  a_addr_write_bit: assert property (state == M_WADDR |->
    acc_addr == DEV_DATA && acc_data == {sla, 1'b0})
    else $error("address byte malformed");
  a_clear_drops_flag: assert property (state == M_CLEAR |->
    !acc_data[FLAG_POS] && !acc_data[HALT_POS] && acc_addr == DEV_CTRL)
    else $error("clear write keeps flag or halt");
  a_data_next_byte: assert property (
    state == M_EVAL && code == ST_ADDR_ACK && idx < len |=>
    state == M_WDATA && idx == 4'($past(idx) + 4'h1))
    else $error("data byte not sent after address ack");
  a_addr_nack_halt: assert property (
    state == M_EVAL && code == ST_ADDR_NACK |=> state == M_HALT && nack)
    else $error("address nack not stopped");
  a_arb_idle: assert property (
    state == M_EVAL && code == ST_ARB_LOST && !retry |=>
    state == M_ARBDATA && !clr_begin && !after_clear)
    else $error("arbitration loss not returned to idle");
  a_slave_rx_ack: assert property (
    state == M_EVAL && code == ST_ARB_SLV_WR |=>
    state == M_CLEAR && acc_data[ACK_ASSERT_POS] == $past(ack_assert_bit))
    else $error("slave receive ack choice wrong");
  a_gcall_ack: assert property (
    state == M_EVAL && code == ST_ARB_GCALL |=>
    state == M_CLEAR && acc_data[ACK_ASSERT_POS] == $past(ack_assert_bit))
    else $error("general call ack choice wrong");
  a_slave_tx_last: assert property (
    state == M_EVAL && code == ST_ARB_SLV_RD |=>
    state == M_WDATA && out_byte == FILL_BYTE && !clr_aak ##1
    acc_data == FILL_BYTE)
    else $error("slave transmit byte wrong");
  a_last_byte_halt: assert property (
    state == M_EVAL && code == ST_DATA_ACK && idx >= len |=>
    state == M_HALT ##1 acc_data[HALT_POS])
    else $error("no halt after last byte");
  a_data_nack_halt: assert property (
    state == M_EVAL && code == ST_DATA_NACK |=> state == M_HALT && nack)
    else $error("data nack not stopped");
  a_halt_waits: assert property (
    state == M_HALTPOLL && acc_done && acc_rdata[HALT_POS] |=>
    state == M_HALTPOLL && !done_f)
    else $error("left halt poll while halt still set");
  a_irq_waits: assert property (
    state == M_IRQ && !irq_s |=> state == M_IRQ)
    else $error("left interrupt wait without request");

  c_data_ack: cover property (state == M_EVAL && code == ST_DATA_ACK);
  c_arb_lost: cover property (state == M_EVAL && code == ST_ARB_LOST);
  c_slave_rd: cover property (state == M_EVAL && code == ST_ARB_SLV_RD);
  c_stop_done: cover property (state == M_HALTPOLL ##1 state == M_IDLE);

endmodule

// *** verif/bus_dev_model.sv ***
module bus_dev_model
  import i2c_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl, data, stat, init_ctrl, arb_byte;
  logic [7:0] ctrl_q, data_q, stat_q;
  logic [7:0] start_code = ST_START;
  logic wr_q, tog, seen, aak_seen, pend;
  int lat, cnt, act;
  logic [7:0] codes[$];
  logic [7:0] sent[$];
  // ==========================================================
  // read port and interrupt
  assign irq_o = ctrl_q[IRQ_ALLOW_POS] & ctrl_q[FLAG_POS];
  // released bus toggles so stale data is never mistaken for valid
  assign rdata_o = !rd_i ? {8{tog}} : addr_i == DEV_CTRL ? ctrl_q :
    addr_i == DEV_DATA ? data_q : stat_q;
  // ==========================================================
  // register writes and transfer sequencing
  always @(posedge clk_i) begin
    wr_q <= wr_i;
    tog <= !tog;
    if (rst_i) begin
      ctrl = 8'h00;
      stat = 8'hF8;
      seen = 0;
      act = 0;
      cnt = 0;
      tog <= 1'b0;
    end else if (wr_i && !wr_q) begin
      if (addr_i == DEV_DATA)
        data = wdata_i;
      if (addr_i == DEV_CTRL) begin
        if (!seen)
          init_ctrl = wdata_i;
        seen = 1;
        pend = ctrl[FLAG_POS] && !wdata_i[FLAG_POS];
        ctrl = {wdata_i[7:4], ctrl[FLAG_POS] && !pend, wdata_i[2], 2'b00};
        cnt = lat;
        act = 0;
        if (wdata_i[HALT_POS])
          act = 3;
        else if (wdata_i[BEGIN_POS])
          act = 1;
        else if (pend && stat inside {ST_ARB_SLV_WR, ST_ARB_GCALL,
            ST_ARB_SLV_RD})
          aak_seen = wdata_i[ACK_ASSERT_POS];
        else if (pend && stat != ST_ARB_LOST)
          act = 2;
      end
    end else if (act != 0 && cnt != 0) begin
      cnt--;
    end else if (act != 0) begin
      // nothing moves until the flag is cleared again
      if (act == 3) begin
        ctrl[HALT_POS] = 0;
      end else begin
        ctrl[FLAG_POS] = 1;
        ctrl[BEGIN_POS] = 0;
        if (act == 1) begin
          stat = start_code;
        end else begin
          sent.push_back(data);
          stat = codes.size() != 0 ? codes.pop_front() :
            (stat inside {ST_START, ST_RESTART}) ? ST_ADDR_ACK :
            ST_DATA_ACK;
          if (stat == ST_ARB_LOST)
            data = arb_byte;
        end
      end
      act = 0;
    end
    // outputs move after the edge, never racing the host's sampling
    ctrl_q <= ctrl;
    data_q <= data;
    stat_q <= stat;
  end
endmodule

// *** verif/i2c_tx_host_tb.sv ***
module i2c_tx_host_tb
  import i2c_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, we, cyc, stb, ack;
  logic [7:0] adr, dev_wdata, dev_rdata;
  logic [31:0] dat, dat_o, st;
  logic [3:0] sel;
  logic [1:0] dev_addr;
  logic dev_wr, dev_rd, dev_irq;
  int num_errors = 0;
  int checks_done = 0;

  i2c_tx_host dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(dat), .dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc),
    .stb_i(stb), .ack_o(ack), .dev_addr_o(dev_addr),
    .dev_wdata_o(dev_wdata), .dev_wr_o(dev_wr), .dev_rd_o(dev_rd),
    .dev_rdata_i(dev_rdata), .dev_irq_i(dev_irq));
  bus_dev_model dev (.clk_i(clk_i), .rst_i(rst_i), .addr_i(dev_addr),
    .wdata_i(dev_wdata), .wr_i(dev_wr), .rd_i(dev_rd),
    .rdata_o(dev_rdata), .irq_o(dev_irq));

  // ==========================================================
  // shared tasks
  task automatic finish_test;
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = dat_o;
    if (n >= 100) begin
      num_errors++;
      finish_test;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic rst_dut;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // cmd holds irq_allow, ack_assert and retry; go is added here
  task automatic run(input logic [3:0] cmd, input int len, input int lat);
    int n;
    rst_dut;
    dev.sent.delete();
    dev.lat = lat;
    wr(WB_SLA, 32'h5A);
    wr(WB_LEN, 32'(len));
    for (int i = 0; i < len; i++)
      wr({WB_TXBUF_PAGE, 3'(i), 2'b00}, 32'h30 + 32'(i));
    wr(WB_CMD, {28'h0, cmd[3:1], 1'b1});
    n = 0;
    do begin
      rd(WB_STAT, st);
      n++;
    end while (st[1] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      num_errors++;
      finish_test;
    end
    chk("init ctrl", {cmd[1], 1'b1, 3'b000, cmd[2], 2'b00},
      dev.init_ctrl);
    chk("busy", 32'h0, {31'h0, st[0]});
  endtask
  task automatic chk_sent(input int n);
    chk("sent count", 32'(n), 32'(dev.sent.size()));
    chk("address byte", 32'hB4, dev.sent[0]);
  endtask

  // ==========================================================
  // scenarios
  task automatic s_regs;
    logic [31:0] q;
    rd(WB_CMD, q);
    chk("cmd reset", 32'h0, q);
    rd(WB_LEN, q);
    chk("len reset", 32'h0, q);
    rd(WB_STAT, q);
    chk("stat reset", 32'h0, {27'h0, q[4:0]});
    wr(8'h10, 32'hFF);
    rd(8'h10, q);
    chk("unmapped", 32'h0, q);
    wr(WB_SLA, 32'hFF);
    rd(WB_SLA, q);
    chk("sla width", 32'h7F, q);
    wr(WB_CMD, 32'h0E);
    rd(WB_CMD, q);
    chk("cmd bits", 32'h0E, q);
  endtask
  task automatic s_write;
    run(4'h2, 8, 30);
    chk_sent(9);
    for (int i = 1; i < 9; i++)
      chk("data byte", 32'h30 + 32'(i - 1), dev.sent[i]);
    chk("flags", 32'h0, {29'h0, st[4:2]});
    chk("last code", ST_DATA_ACK, st[15:8]);
    chk("halt cleared", 32'h0, dev.ctrl[HALT_POS]);
    dev.start_code = ST_RESTART;
    run(4'h4, 1, 0);
    chk_sent(2);
    chk("restart last code", ST_DATA_ACK, st[15:8]);
    dev.start_code = ST_START;
  endtask
  task automatic s_nack;
    dev.codes.push_back(ST_ADDR_NACK);
    run(4'h0, 2, 5);
    chk_sent(1);
    chk("nack", 32'h1, st[2]);
    chk("code", ST_ADDR_NACK, st[15:8]);
    dev.codes.push_back(ST_ADDR_ACK);
    dev.codes.push_back(ST_DATA_NACK);
    run(4'h0, 3, 5);
    chk_sent(2);
    chk("nack", 32'h1, st[2]);
    chk("halt cleared", 32'h0, dev.ctrl[HALT_POS]);
    // a code outside the transmit set must end the transfer with STOP
    dev.codes.push_back(8'h00);
    run(4'h0, 1, 5);
    chk_sent(1);
    chk("bad code", 32'h1, st[4]);
    chk("bad code seen", 32'h0, st[15:8]);
  endtask
  task automatic s_arb;
    dev.arb_byte = 8'hC3;
    dev.codes.push_back(ST_ARB_LOST);
    run(4'h0, 2, 5);
    chk_sent(1);
    chk("arb", 32'h1, st[3]);
    chk("bus byte", 32'hC3, st[23:16]);
    dev.codes.push_back(ST_ARB_LOST);
    run(4'h8, 1, 5);
    chk_sent(3);
    chk("retry code", ST_DATA_ACK, st[15:8]);
  endtask
  task automatic s_slave;
    logic [7:0] c[2] = '{ST_ARB_SLV_WR, ST_ARB_GCALL};
    for (int i = 0; i < 4; i++) begin
      dev.codes.push_back(c[i[1]]);
      run({1'b0, i[0], 2'b00}, 1, 5);
      chk("ack assert", {31'h0, i[0]}, dev.aak_seen);
      chk("code", c[i[1]], st[15:8]);
    end
    dev.codes.push_back(ST_ARB_SLV_RD);
    run(4'h4, 1, 5);
    chk("ack assert", 32'h0, dev.aak_seen);
    chk("fill byte", FILL_BYTE, dev.data);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'hF;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_regs;
    s_write;
    s_nack;
    s_arb;
    s_slave;
    finish_test;
  end
endmodule
